// File: remappable_pin_output_map_lock.v
// Contract
// (R01) Each output-map register holds two 6-bit pin selector fields.
// (R02) A pin drives its selected peripheral output; code zero leaves it disconnected.
// (R03) Codes 0-15: none, comparators, serial ports, SPI1, SPI2, compare 1-3.
// (R04) Codes 16-31: capture units, reserved 22, SPI3, comparator 3, calendar, clock, cells.
// (R05) Only contention is prevented; fan-in and fan-out of mappings are allowed.
// (R06) Input code of an unimplemented pin is invalid and connects nothing.
// (R07) Output fields of unimplemented pins ignore writes.
// (R08) Locked map writes complete but change nothing.
// (R09) Lock is bit 6 of the oscillator control register.
// (R10) Lock changes only after writing 46h then 57h to the low byte.
// (R11) Lock holds its value until changed; one unlock allows many writes.
// (R12) Map registers are compared with shadows; a difference raises mismatch reset.
// (R13) With the one-way fuse set, lock cannot be cleared after being set.
// (R14) Under the one-way fuse a set lock ignores unlock until device reset.
// (R15) Fuse set by default allows one session; programmed allows unlimited sessions.
// (R16) Variants: 29 plus 4 input-only, 29 only, or 19 without pins 16-25.
// (R17) Each input-map field is 6 bits and selects the feeding pin by number.
// (R18) Input fields reset to all ones, output fields reset to zero.
// (R19) The lock comes out of reset unlocked.
// (R20) Key writes must be back to back accesses; anything between aborts.
// (R21) Permitted map writes update the shadow copy at the same time.
`timescale 1ns/1ps
`include "pin_remap_consts.vh"

module remappable_pin_output_map_lock #(
  parameter VARIANT = `VARIANT_LARGE
) (
  input wire mclk,
  input wire reset_n,
  input wire [`ADDR_W-1:0] reg_addr,
  input wire [`DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`DATA_W-1:0] reg_rdata,
  input wire one_way_lock_fuse,
  input wire comparator1_out,
  input wire comparator2_out,
  input wire comparator3_out,
  input wire serial1_transmit,
  input wire serial1_request_to_send,
  input wire serial2_transmit,
  input wire serial2_request_to_send,
  input wire spi1_data_out,
  input wire spi1_clock_out,
  input wire spi1_select_out,
  input wire spi2_data_out,
  input wire spi2_clock_out,
  input wire spi2_select_out,
  input wire spi3_data_out,
  input wire spi3_clock_out,
  input wire spi3_select_out,
  input wire compare1_out,
  input wire compare2_out,
  input wire compare3_out,
  input wire ccu2_out_a,
  input wire ccu2_out_b,
  input wire ccu3_out_a,
  input wire ccu3_out_b,
  input wire ccu4_out_a,
  input wire ccu4_out_b,
  input wire calendar_power_gate,
  input wire reference_clock_out,
  input wire logic_cell1_out,
  input wire logic_cell2_out,
  input wire calendar_clock_out,
  input wire [`NUM_ALL_PINS-1:0] remap_pin_in,
  output reg [`NUM_IO_PINS-1:0] remap_io_pin_out,
  output reg [`NUM_IO_PINS-1:0] remap_io_pin_oe,
  output reg [2*`NUM_IN_MAP_REGS-1:0] peripheral_in,
  output reg map_write_lock,
  output reg config_mismatch_reset
);
  localparam NUM_IN_FIELDS = 2 * `NUM_IN_MAP_REGS;
  localparam NUM_OUT_FIELDS = 2 * `NUM_OUT_MAP_REGS;
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_KEY1 = 3'b010;
  localparam [2:0] ST_KEY2 = 3'b100;
  localparam [`DATA_W-1:0] FIELD_MASK = 16'h3F3F;

  // ==========================================================================
  // Decode helpers.
  function pin_implemented;
    input integer n;
    begin
      if (n < `NUM_IO_PINS)
        pin_implemented = !((VARIANT == `VARIANT_SMALL) && (n >= `SMALL_GAP_LO) && (n <= `SMALL_GAP_HI)); // R16
      else if (n < `NUM_ALL_PINS)
        pin_implemented = (VARIANT == `VARIANT_LARGE); // R16
      else
        pin_implemented = 1'b0;
    end
  endfunction

  function [`DATA_W-1:0] out_write_mask;
    input integer r;
    begin
      out_write_mask = `DATA_ZERO;
      if (pin_implemented(2 * r))
        out_write_mask[`FIELD_LO_POS +: `FIELD_W] = {`FIELD_W{1'b1}}; // R07
      if ((2 * r + 1 < `NUM_IO_PINS) && pin_implemented(2 * r + 1))
        out_write_mask[`FIELD_HI_POS +: `FIELD_W] = {`FIELD_W{1'b1}}; // R07
    end
  endfunction

  // ==========================================================================
  // Pin synchronisers.
  wire [`NUM_ALL_PINS-1:0] pin_level;

  pin_input_sync #(
    .WIDTH(`NUM_ALL_PINS)
  ) u_pin_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .pin_async(remap_pin_in),
    .pin_level(pin_level)
  );

  // ==========================================================================
  // Peripheral output sources indexed by selector code.
  wire [`NUM_CODES-1:0] source;

  assign source[`CODE_NONE] = 1'b0; // R03
  assign source[`CODE_COMPARATOR1] = comparator1_out; // R03
  assign source[`CODE_COMPARATOR2] = comparator2_out;
  assign source[`CODE_SERIAL1_TX] = serial1_transmit;
  assign source[`CODE_SERIAL1_RTS] = serial1_request_to_send;
  assign source[`CODE_SERIAL2_TX] = serial2_transmit;
  assign source[`CODE_SERIAL2_RTS] = serial2_request_to_send;
  assign source[`CODE_SPI1_DATA] = spi1_data_out;
  assign source[`CODE_SPI1_CLOCK] = spi1_clock_out;
  assign source[`CODE_SPI1_SELECT] = spi1_select_out;
  assign source[`CODE_SPI2_DATA] = spi2_data_out;
  assign source[`CODE_SPI2_CLOCK] = spi2_clock_out;
  assign source[`CODE_SPI2_SELECT] = spi2_select_out;
  assign source[`CODE_COMPARE1] = compare1_out;
  assign source[`CODE_COMPARE2] = compare2_out;
  assign source[`CODE_COMPARE3] = compare3_out;
  assign source[`CODE_CCU2_A] = ccu2_out_a; // R04
  assign source[`CODE_CCU2_B] = ccu2_out_b;
  assign source[`CODE_CCU3_A] = ccu3_out_a;
  assign source[`CODE_CCU3_B] = ccu3_out_b;
  assign source[`CODE_CCU4_A] = ccu4_out_a;
  assign source[`CODE_CCU4_B] = ccu4_out_b;
  assign source[`CODE_RESERVED] = 1'b0; // R04
  assign source[`CODE_SPI3_DATA] = spi3_data_out;
  assign source[`CODE_SPI3_CLOCK] = spi3_clock_out;
  assign source[`CODE_SPI3_SELECT] = spi3_select_out;
  assign source[`CODE_COMPARATOR3] = comparator3_out;
  assign source[`CODE_CAL_POWER] = calendar_power_gate;
  assign source[`CODE_REF_CLOCK] = reference_clock_out;
  assign source[`CODE_LOGIC_CELL1] = logic_cell1_out;
  assign source[`CODE_LOGIC_CELL2] = logic_cell2_out;
  assign source[`CODE_CAL_CLOCK] = calendar_clock_out;

  // ==========================================================================
  // Bus decode.
  reg [`DATA_W-1:0] in_map_reg [0:`NUM_IN_MAP_REGS-1];
  reg [`DATA_W-1:0] in_shadow_reg [0:`NUM_IN_MAP_REGS-1];
  reg [`DATA_W-1:0] out_map_reg [0:`NUM_OUT_MAP_REGS-1];
  reg [`DATA_W-1:0] out_shadow_reg [0:`NUM_OUT_MAP_REGS-1];
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg lock_next;
  reg fuse_reg;
  reg fuse_taken_reg;
  reg mismatch_next;
  reg [`DATA_W-1:0] rdata_next;
  wire wr_osc;
  wire map_write_ok;
  integer i;
  integer j;
  integer k;

  assign wr_osc = reg_wr && (reg_addr == `ADDR_OSC_CTRL);
  assign map_write_ok = reg_wr && !map_write_lock; // R08 R09

  // ==========================================================================
  // Fuse capture after reset release. Until it is taken the fuse reads as
  // set, so the restrictive setting applies for that first cycle.
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fuse_reg <= 1'b1;
      fuse_taken_reg <= 1'b0;
    end else if (!fuse_taken_reg) begin
      fuse_reg <= one_way_lock_fuse; // R15
      fuse_taken_reg <= 1'b1;
    end
  end

  // ==========================================================================
  // Unlock sequence and lock bit.
  always @* begin
    state_next = state_reg;
    lock_next = map_write_lock; // R11
    case (state_reg)
      ST_IDLE: begin
        if (wr_osc && (reg_wdata[`KEY_MSB:0] == `UNLOCK_KEY1) && !(fuse_reg && map_write_lock))
          state_next = ST_KEY1; // R10 R14
      end
      ST_KEY1: begin
        if (wr_osc && (reg_wdata[`KEY_MSB:0] == `UNLOCK_KEY2))
          state_next = ST_KEY2; // R10
        else if (reg_wr || reg_rd)
          state_next = ST_IDLE; // R20
      end
      ST_KEY2: begin
        if (wr_osc) begin
          if (!(fuse_reg && map_write_lock))
            lock_next = reg_wdata[`LOCK_BIT]; // R09 R10 R13
          state_next = ST_IDLE;
        end else if (reg_wr || reg_rd) begin
          state_next = ST_IDLE; // R20
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      map_write_lock <= 1'b0; // R19
    end else begin
      state_reg <= state_next;
      map_write_lock <= lock_next;
    end
  end

  // ==========================================================================
  // Map registers and their shadows. A write goes to both copies in the
  // same cycle so that only a disturbance of one copy shows as a mismatch.
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (i = 0; i < `NUM_IN_MAP_REGS; i = i + 1) begin
        in_map_reg[i] <= {2'b00, `IN_FIELD_RESET, 2'b00, `IN_FIELD_RESET}; // R18
        in_shadow_reg[i] <= {2'b00, `IN_FIELD_RESET, 2'b00, `IN_FIELD_RESET};
      end
      for (i = 0; i < `NUM_OUT_MAP_REGS; i = i + 1) begin
        out_map_reg[i] <= {2'b00, `OUT_FIELD_RESET, 2'b00, `OUT_FIELD_RESET}; // R18
        out_shadow_reg[i] <= {2'b00, `OUT_FIELD_RESET, 2'b00, `OUT_FIELD_RESET};
      end
    end else if (map_write_ok) begin
      for (i = 0; i < `NUM_IN_MAP_REGS; i = i + 1) begin
        if (reg_addr == `ADDR_IN_MAP_BASE + i[`ADDR_W-1:0]) begin
          in_map_reg[i] <= reg_wdata & FIELD_MASK; // R17
          in_shadow_reg[i] <= reg_wdata & FIELD_MASK; // R21
        end
      end
      for (i = 0; i < `NUM_OUT_MAP_REGS; i = i + 1) begin
        if (reg_addr == `ADDR_OUT_MAP_BASE + i[`ADDR_W-1:0]) begin
          out_map_reg[i] <= (reg_wdata & out_write_mask(i)) | (out_map_reg[i] & ~out_write_mask(i)); // R01 R07
          out_shadow_reg[i] <= (reg_wdata & out_write_mask(i)) | (out_shadow_reg[i] & ~out_write_mask(i)); // R21
        end
      end
    end
  end

  // ==========================================================================
  // Continuous shadow comparison. Each process keeps its own loop index so
  // that no two processes wake each other through a shared variable.
  always @* begin
    mismatch_next = 1'b0;
    for (j = 0; j < `NUM_IN_MAP_REGS; j = j + 1)
      mismatch_next = mismatch_next | (in_map_reg[j] != in_shadow_reg[j]); // R12
    for (j = 0; j < `NUM_OUT_MAP_REGS; j = j + 1)
      mismatch_next = mismatch_next | (out_map_reg[j] != out_shadow_reg[j]); // R12
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      config_mismatch_reset <= 1'b0;
    else
      config_mismatch_reset <= mismatch_next; // R12
  end

  // ==========================================================================
  // Read port.
  always @* begin
    rdata_next = `DATA_ZERO;
    if (reg_addr == `ADDR_OSC_CTRL) begin
      rdata_next[`LOCK_BIT] = map_write_lock;
      rdata_next[`FUSE_STATUS_BIT] = fuse_reg;
    end
    for (k = 0; k < `NUM_IN_MAP_REGS; k = k + 1)
      if (reg_addr == `ADDR_IN_MAP_BASE + k[`ADDR_W-1:0])
        rdata_next = in_map_reg[k];
    for (k = 0; k < `NUM_OUT_MAP_REGS; k = k + 1)
      if (reg_addr == `ADDR_OUT_MAP_BASE + k[`ADDR_W-1:0])
        rdata_next = out_map_reg[k];
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      reg_rdata <= `DATA_ZERO;
    else if (reg_rd)
      reg_rdata <= rdata_next;
    else
      reg_rdata <= `DATA_ZERO;
  end

  // ==========================================================================
  // Output mapping: one selector per pin. Several pins may pick the same
  // source; each pin has exactly one selector, so two outputs never meet.
  genvar p;
  generate
    for (p = 0; p < `NUM_IO_PINS; p = p + 1) begin : g_out_pin
      wire [`FIELD_W-1:0] code;
      wire active;

      assign code = out_map_reg[p / 2][(p % 2) * `FIELD_HI_POS +: `FIELD_W]; // R01
      assign active = (code != `CODE_NONE) && (code < `NUM_CODES) && (code != `CODE_RESERVED); // R02 R04

      always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          remap_io_pin_out[p] <= 1'b0;
          remap_io_pin_oe[p] <= 1'b0;
        end else begin
          remap_io_pin_out[p] <= active & source[code[4:0]]; // R02 R05
          remap_io_pin_oe[p] <= active; // R02
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Input mapping: one selector per peripheral input; one pin may feed many.
  // An invalid code, including the reset value, holds the input low.
  genvar f;
  generate
    for (f = 0; f < NUM_IN_FIELDS; f = f + 1) begin : g_in_field
      wire [`FIELD_W-1:0] code;
      wire valid;

      assign code = in_map_reg[f / 2][(f % 2) * `FIELD_HI_POS +: `FIELD_W]; // R17
      assign valid = pin_implemented(code); // R06

      always @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
          peripheral_in[f] <= 1'b0;
        else
          peripheral_in[f] <= valid ? pin_level[code] : 1'b0; // R05 R06
      end
    end
  endgenerate
endmodule // remappable_pin_output_map_lock

// File: pin_remap_consts.vh
`ifndef PIN_REMAP_CONSTS_VH
`define PIN_REMAP_CONSTS_VH

// ==========================================================================
// Register addresses and widths.
`define ADDR_W 8
`define DATA_W 16
`define ADDR_OSC_CTRL 8'h00
`define ADDR_IN_MAP_BASE 8'h10
`define ADDR_OUT_MAP_BASE 8'h30
`define NUM_IN_MAP_REGS 19
`define NUM_OUT_MAP_REGS 15

// ==========================================================================
// Field layout.
`define FIELD_W 6
`define FIELD_LO_POS 0
`define FIELD_HI_POS 8
`define LOCK_BIT 6
`define FUSE_STATUS_BIT 5
`define KEY_MSB 7

// ==========================================================================
// Unlock keys and reset values.
`define UNLOCK_KEY1 8'h46
`define UNLOCK_KEY2 8'h57
`define IN_FIELD_RESET 6'h3F
`define OUT_FIELD_RESET 6'h00
`define DATA_ZERO 16'h0000

// ==========================================================================
// Output selector codes.
`define CODE_NONE 0
`define CODE_COMPARATOR1 1
`define CODE_COMPARATOR2 2
`define CODE_SERIAL1_TX 3
`define CODE_SERIAL1_RTS 4
`define CODE_SERIAL2_TX 5
`define CODE_SERIAL2_RTS 6
`define CODE_SPI1_DATA 7
`define CODE_SPI1_CLOCK 8
`define CODE_SPI1_SELECT 9
`define CODE_SPI2_DATA 10
`define CODE_SPI2_CLOCK 11
`define CODE_SPI2_SELECT 12
`define CODE_COMPARE1 13
`define CODE_COMPARE2 14
`define CODE_COMPARE3 15
`define CODE_CCU2_A 16
`define CODE_CCU2_B 17
`define CODE_CCU3_A 18
`define CODE_CCU3_B 19
`define CODE_CCU4_A 20
`define CODE_CCU4_B 21
`define CODE_RESERVED 22
`define CODE_SPI3_DATA 23
`define CODE_SPI3_CLOCK 24
`define CODE_SPI3_SELECT 25
`define CODE_COMPARATOR3 26
`define CODE_CAL_POWER 27
`define CODE_REF_CLOCK 28
`define CODE_LOGIC_CELL1 29
`define CODE_LOGIC_CELL2 30
`define CODE_CAL_CLOCK 31
`define NUM_CODES 32

// ==========================================================================
// Pin counts and variants.
`define NUM_IO_PINS 29
`define NUM_INPUT_ONLY_PINS 4
`define NUM_ALL_PINS 33
`define SMALL_GAP_LO 16
`define SMALL_GAP_HI 25
`define VARIANT_LARGE 0
`define VARIANT_MIDDLE 1
`define VARIANT_SMALL 2

`endif

// File: pin_input_sync.v
`timescale 1ns/1ps

// ==========================================================================
// Three-stage pin synchroniser; a new level is taken only once the second
// and third stages agree, which filters a one-cycle glitch.
module pin_input_sync #(
  parameter WIDTH = 33
) (
  input wire mclk,
  input wire reset_n,
  input wire [WIDTH-1:0] pin_async,
  output reg [WIDTH-1:0] pin_level
);
  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;
  reg [WIDTH-1:0] stage3_reg;
  wire [WIDTH-1:0] agree;

  assign agree = ~(stage2_reg ^ stage3_reg);

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_reg <= {WIDTH{1'b0}};
      stage2_reg <= {WIDTH{1'b0}};
      stage3_reg <= {WIDTH{1'b0}};
      pin_level <= {WIDTH{1'b0}};
    end else begin
      stage1_reg <= pin_async;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      pin_level <= (agree & stage2_reg) | (~agree & pin_level);
    end
  end
endmodule // pin_input_sync

// File: pin_map_checker.sv
`timescale 1ns/1ps
`include "pin_remap_consts.vh"
// ==========================================================================
// Port-level properties of the remap block; one clock, one reset.
module pin_map_checker (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [`ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`DATA_W-1:0] reg_rdata,
  input wire logic one_way_lock_fuse,
  input wire logic [`NUM_IO_PINS-1:0] remap_io_pin_out,
  input wire logic [`NUM_IO_PINS-1:0] remap_io_pin_oe,
  input wire logic map_write_lock,
  input wire logic config_mismatch_reset
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  pin_idle_low_a: assert property ((remap_io_pin_out & ~remap_io_pin_oe) == 0)
    else $error("undriven pin shows data");
  oe_after_write_a: assert property ($changed(remap_io_pin_oe) |->
    $past(reg_wr && reg_addr >= `ADDR_OUT_MAP_BASE, 2))
    else $error("pin enable changed without a selector write");
  locked_stable_a: assert property ((map_write_lock && reg_wr && reg_addr >= `ADDR_IN_MAP_BASE) |=>
    $stable(remap_io_pin_oe) [*2])
    else $error("locked write changed a pin");
  lock_cause_a: assert property ($changed(map_write_lock) |->
    $past(reg_wr && reg_addr == `ADDR_OSC_CTRL))
    else $error("lock changed without a control write");
  one_way_hold_a: assert property ((one_way_lock_fuse && map_write_lock) |=> map_write_lock)
    else $error("lock cleared under one-way fuse");
  lock_unset_a: assert property ($rose(reset_n) |-> !map_write_lock)
    else $error("lock set after reset");
  osc_read_a: assert property ($past(reg_rd && reg_addr == `ADDR_OSC_CTRL) |->
    reg_rdata[6] == map_write_lock && reg_rdata[15:7] == 0 && reg_rdata[4:0] == 0)
    else $error("control read does not show the lock");
  map_pad_a: assert property ($past(reg_rd && reg_addr >= `ADDR_IN_MAP_BASE) |->
    reg_rdata[15:14] == 2'b00 && reg_rdata[7:6] == 2'b00)
    else $error("map register pad bits set");
  no_mismatch_a: assert property (!config_mismatch_reset)
    else $error("mismatch reset after legal writes");
endmodule // pin_map_checker

bind remappable_pin_output_map_lock pin_map_checker chk_u (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .one_way_lock_fuse(one_way_lock_fuse),
  .remap_io_pin_out(remap_io_pin_out), .remap_io_pin_oe(remap_io_pin_oe), .map_write_lock(map_write_lock),
  .config_mismatch_reset(config_mismatch_reset));

// File: periph_pin_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Peripherals and pads. Sources change every cycle so that a wrong selector
// cannot match by luck.
module periph_pin_model (
  input wire logic mclk,
  input wire logic [32:0] pad_level,
  output logic [31:0] periph_src,
  output logic [32:0] pad_in
);
  initial periph_src = 32'h0000_0000;
  always @(posedge mclk) begin
    periph_src <= $urandom;
  end
  assign pad_in = pad_level;
endmodule // periph_pin_model

// File: test_remappable_pin_output_map_lock.sv
`timescale 1ns/1ps
`include "pin_remap_consts.vh"
// ==========================================================================
// Register-level reference model; every pin and input, and every read of dut_u, is compared.
module test_remappable_pin_output_map_lock;
  logic mclk, reset_n, reg_wr, reg_rd, fuse, lock, mism;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [31:0] src, src_q;
  logic [32:0] pads, pad_in;
  logic [28:0] pin_out, pin_oe;
  logic [37:0] periph_in;
  logic [28:0] pin_out2, pin_oe2;
  logic [37:0] periph_in2;
  logic lock2, mism2;
  logic [15:0] in_m [19];
  logic [15:0] out_m [15];
  int miscompares, total_checks, ks, m_lock, m_fuse;

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) src_q <= src;

  periph_pin_model model_u (.mclk(mclk), .pad_level(pads), .periph_src(src), .pad_in(pad_in));
  remappable_pin_output_map_lock dut_u (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .one_way_lock_fuse(fuse),
    .comparator1_out(src[1]), .comparator2_out(src[2]), .serial1_transmit(src[3]), .serial1_request_to_send(src[4]),
    .serial2_transmit(src[5]), .serial2_request_to_send(src[6]), .spi1_data_out(src[7]), .spi1_clock_out(src[8]),
    .spi1_select_out(src[9]), .spi2_data_out(src[10]), .spi2_clock_out(src[11]), .spi2_select_out(src[12]),
    .compare1_out(src[13]), .compare2_out(src[14]), .compare3_out(src[15]), .ccu2_out_a(src[16]),
    .ccu2_out_b(src[17]), .ccu3_out_a(src[18]), .ccu3_out_b(src[19]), .ccu4_out_a(src[20]), .ccu4_out_b(src[21]),
    .spi3_data_out(src[23]), .spi3_clock_out(src[24]), .spi3_select_out(src[25]), .comparator3_out(src[26]),
    .calendar_power_gate(src[27]), .reference_clock_out(src[28]), .logic_cell1_out(src[29]),
    .logic_cell2_out(src[30]), .calendar_clock_out(src[31]), .remap_pin_in(pad_in), .remap_io_pin_out(pin_out),
    .remap_io_pin_oe(pin_oe), .peripheral_in(periph_in), .map_write_lock(lock), .config_mismatch_reset(mism));
  // A small variant on the same bus shows that absent pins stay dead.
  remappable_pin_output_map_lock #(.VARIANT(`VARIANT_SMALL)) small_u (.mclk(mclk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(),
    .one_way_lock_fuse(fuse),
    .comparator1_out(src[1]), .comparator2_out(src[2]), .serial1_transmit(src[3]), .serial1_request_to_send(src[4]),
    .serial2_transmit(src[5]), .serial2_request_to_send(src[6]), .spi1_data_out(src[7]), .spi1_clock_out(src[8]),
    .spi1_select_out(src[9]), .spi2_data_out(src[10]), .spi2_clock_out(src[11]), .spi2_select_out(src[12]),
    .compare1_out(src[13]), .compare2_out(src[14]), .compare3_out(src[15]), .ccu2_out_a(src[16]),
    .ccu2_out_b(src[17]), .ccu3_out_a(src[18]), .ccu3_out_b(src[19]), .ccu4_out_a(src[20]), .ccu4_out_b(src[21]),
    .spi3_data_out(src[23]), .spi3_clock_out(src[24]), .spi3_select_out(src[25]), .comparator3_out(src[26]),
    .calendar_power_gate(src[27]), .reference_clock_out(src[28]), .logic_cell1_out(src[29]),
    .logic_cell2_out(src[30]), .calendar_clock_out(src[31]), .remap_pin_in(pad_in), .remap_io_pin_out(pin_out2),
    .remap_io_pin_oe(pin_oe2), .peripheral_in(periph_in2), .map_write_lock(lock2), .config_mismatch_reset(mism2));

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic do_reset(input logic f);
    @(posedge mclk);
    reset_n <= 1'b0;
    fuse <= f;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    m_lock = 0;
    ks = 0;
    m_fuse = f;
    foreach (in_m[i]) in_m[i] = 16'h3F3F;
    foreach (out_m[i]) out_m[i] = 16'h0000;
    repeat (2) @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    if (a == `ADDR_OSC_CTRL) begin
      if (ks == 2 && !(m_fuse && m_lock)) m_lock = d[`LOCK_BIT];
      ks = (ks == 1 && d[7:0] == `UNLOCK_KEY2) ? 2 : (ks == 0 && d[7:0] == `UNLOCK_KEY1 && !(m_fuse && m_lock)) ? 1 : 0;
    end else begin
      ks = 0;
      if (!m_lock && a >= `ADDR_IN_MAP_BASE && a < `ADDR_IN_MAP_BASE + `NUM_IN_MAP_REGS) begin
        in_m[a - `ADDR_IN_MAP_BASE] = d & 16'h3F3F;
      end
      if (!m_lock && a >= `ADDR_OUT_MAP_BASE && a < `ADDR_OUT_MAP_BASE + `NUM_OUT_MAP_REGS) begin
        out_m[a - `ADDR_OUT_MAP_BASE] = d & ((a == 8'h3E) ? 16'h003F : 16'h3F3F);
      end
    end
  endtask

  task automatic rd(input logic [7:0] a);
    logic [15:0] e;
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    e = 16'h0000;
    ks = 0;
    if (a == `ADDR_OSC_CTRL) e = {9'h000, m_lock[0], m_fuse[0], 5'h00};
    if (a >= `ADDR_IN_MAP_BASE && a < `ADDR_IN_MAP_BASE + `NUM_IN_MAP_REGS) e = in_m[a - `ADDR_IN_MAP_BASE];
    if (a >= `ADDR_OUT_MAP_BASE && a < `ADDR_OUT_MAP_BASE + `NUM_OUT_MAP_REGS) e = out_m[a - `ADDR_OUT_MAP_BASE];
    @(negedge mclk);
    chk("read data", reg_rdata, e);
    chk("lock output", lock, m_lock[0]);
    chk("small lock", lock2, m_lock[0]);
  endtask

  // Key writes go out back to back with one idle cycle, which the block allows.
  task automatic lock_seq(input logic [7:0] k1, input logic [7:0] k2, input logic v);
    wr(`ADDR_OSC_CTRL, {8'h00, k1});
    wr(`ADDR_OSC_CTRL, {8'h00, k2});
    wr(`ADDR_OSC_CTRL, {9'h000, v, 6'h00});
    rd(`ADDR_OSC_CTRL);
  endtask

  task automatic check_pins();
    logic [5:0] c;
    logic v, gap;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    for (int p = 0; p < `NUM_IO_PINS; p++) begin
      c = p[0] ? out_m[p / 2][13:8] : out_m[p / 2][5:0];
      v = c != 0 && c != 22 && c < 32;
      chk("pin enable", pin_oe[p], v);
      chk("pin data", pin_out[p], v ? src_q[c[4:0]] : 1'b0);
      gap = p >= `SMALL_GAP_LO && p <= `SMALL_GAP_HI;
      chk("small pin enable", pin_oe2[p], gap ? 1'b0 : v);
      chk("small pin data", pin_out2[p], (gap || !v) ? 1'b0 : src_q[c[4:0]]);
    end
    chk("mismatch", mism, 1'b0);
    chk("small mismatch", mism2, 1'b0);
  endtask

  task automatic check_inputs();
    logic [5:0] c;
    logic ok2;
    repeat (7) @(posedge mclk);
    @(negedge mclk);
    for (int f = 0; f < 2 * `NUM_IN_MAP_REGS; f++) begin
      c = f[0] ? in_m[f / 2][13:8] : in_m[f / 2][5:0];
      chk("peripheral input", periph_in[f], (c < `NUM_ALL_PINS) ? pads[c] : 1'b0);
      ok2 = c < `NUM_IO_PINS && (c < `SMALL_GAP_LO || c > `SMALL_GAP_HI);
      chk("small peripheral input", periph_in2[f], ok2 ? pads[c] : 1'b0);
    end
  endtask

  initial begin
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    fuse = 1'b0;
    pads = 33'h0_0000_0000;
    void'($urandom(32'h582C));
    do_reset(1'b0);
    for (int a = 0; a < 64; a++) rd(a[7:0]);
    check_inputs();
    $display("test reset values done");
    for (int c = 0; c < 32; c++) begin
      wr(8'h30 + 8'(c % 15), {2'b11, 6'(c), 2'b11, 6'(31 - c)});
      rd(8'h30 + 8'(c % 15));
      check_pins();
    end
    wr(8'h31, 16'hFFFF);
    check_pins();
    $display("test output selectors done");
    for (int k = 0; k < 24; k++) begin
      @(posedge mclk);
      pads <= {1'($urandom), 32'($urandom)};
      wr(8'h10 + 8'(k % 19), 16'($urandom));
      check_inputs();
    end
    $display("test input selectors done");
    lock_seq(`UNLOCK_KEY1, `UNLOCK_KEY2, 1'b1);
    wr(8'h30, 16'h0101);
    wr(8'h10, 16'h0202);
    rd(8'h30);
    rd(8'h10);
    check_pins();
    lock_seq(8'h46, 8'h58, 1'b0);
    lock_seq(8'h46, 8'h46, 1'b0);
    wr(`ADDR_OSC_CTRL, 16'h0046);
    rd(8'h10);
    lock_seq(8'h57, 8'h00, 1'b0);
    lock_seq(`UNLOCK_KEY1, `UNLOCK_KEY2, 1'b0);
    wr(8'h30, 16'h0303);
    wr(8'h31, 16'h0404);
    rd(8'h30);
    rd(8'h31);
    check_pins();
    lock_seq(`UNLOCK_KEY1, `UNLOCK_KEY2, 1'b1);
    lock_seq(`UNLOCK_KEY1, `UNLOCK_KEY2, 1'b0);
    $display("test lock sequence done");
    do_reset(1'b1);
    rd(`ADDR_OSC_CTRL);
    wr(8'h32, 16'h0505);
    lock_seq(`UNLOCK_KEY1, `UNLOCK_KEY2, 1'b1);
    lock_seq(`UNLOCK_KEY1, `UNLOCK_KEY2, 1'b0);
    wr(8'h32, 16'h0606);
    rd(8'h32);
    check_pins();
    do_reset(1'b1);
    rd(`ADDR_OSC_CTRL);
    $display("test one-way fuse done");
    give_verdict();
  end

  initial begin
    repeat (50000) @(posedge mclk);
    miscompares++;
    give_verdict();
  end
endmodule // test_remappable_pin_output_map_lock
